// File: bench/ebc_link_asserts.sv
// Checker for the two link wires between the master end and the encoder end.
// Assumes ma and slo are registered in the same clk domain as this checker.
`timescale 1ns/1ns
module ebc_link_asserts (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Link wires
	input  wire logic ma,
	input  wire logic slo
);
	// ==========================================================
	// Frame tracker
	logic        ma_d_ff, slo_d_ff, busy_ff, data_ff, done_ff;
	logic        nxt_busy, nxt_data, nxt_done;
	logic [10:0] quiet_ff, nxt_quiet;
	logic [11:0] bcnt_ff, nxt_bcnt;
	logic [6:0]  nbit_ff, nxt_nbit;
	logic [59:0] cap_ff, nxt_cap;

	function automatic logic [5:0] chk6(input logic [51:0] w);
		logic [5:0] c;
		c = 6'h00;
		for (int i = 51; i >= 0; i--) begin
			c = {c[4:0], 1'b0} ^ ((c[5] ^ w[i]) ? 6'h03 : 6'h00);
		end
		return c;
	endfunction

	always_comb begin
		nxt_quiet = (ma != ma_d_ff) ? 11'h000 : quiet_ff + {10'h000, quiet_ff != 11'h7FF};
		nxt_busy  = busy_ff;
		nxt_bcnt  = bcnt_ff + 12'h001;
		nxt_data  = data_ff;
		nxt_nbit  = nbit_ff;
		nxt_cap   = cap_ff;
		nxt_done  = 1'b0;
		// Long high before the fall keeps the post-frame drop of ma from opening a frame
		if (!busy_ff && !data_ff && ma_d_ff && !ma && slo && quiet_ff >= 11'h014) begin
			nxt_busy = 1'b1;
			nxt_bcnt = 12'h000;
		end
		if (busy_ff && slo && !slo_d_ff) begin
			nxt_busy = 1'b0;
			nxt_data = 1'b1;
			nxt_nbit = 7'h00;
		end
		// Sample where the master does, on the falling edge
		if (data_ff && ma_d_ff && !ma) begin
			nxt_cap  = {cap_ff[58:0], slo};
			nxt_nbit = nbit_ff + 7'h01;
			if (nbit_ff == 7'h3B) begin
				nxt_data = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		ma_d_ff  <= ma;
		slo_d_ff <= slo;
		bcnt_ff  <= nxt_bcnt;
		nbit_ff  <= nxt_nbit;
		cap_ff   <= nxt_cap;
		quiet_ff <= rst_n ? nxt_quiet : 11'h000;
		busy_ff  <= rst_n & nxt_busy;
		data_ff  <= rst_n & nxt_data;
		done_ff  <= rst_n & nxt_done;
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	busy_min_a: assert property ($rose(slo) && busy_ff |-> bcnt_ff >= 12'h56C)
		else $error("start bit before the least busy time");
	busy_max_a: assert property (busy_ff |-> bcnt_ff <= 12'h63C)
		else $error("busy longer than allowed");
	busy_low_a: assert property (busy_ff && bcnt_ff > 12'h008 && bcnt_ff < 12'h56C |-> !slo)
		else $error("data line not low while busy");
	tout_min_a: assert property ($rose(slo) && !busy_ff |-> quiet_ff < 11'h008 || quiet_ff >= 11'h064)
		else $error("timeout ended too early");
	tout_max_a: assert property (quiet_ff >= 11'h0FF |-> slo)
		else $error("data line low too long after last edge");
	tout_entry_a: assert property (done_ff |-> ##[1:20] !slo)
		else $error("no timeout after the last check bit");
	crc_ok_a: assert property (done_ff |-> cap_ff[5:0] == ~chk6(cap_ff[57:6]))
		else $error("check value on the wire is wrong");
	ma_rate_a: assert property ($changed(ma) && (busy_ff || data_ff) |-> quiet_ff inside {[11'h002:11'h030]})
		else $error("link clock level outside rate limits");
endmodule // ebc_link_asserts

// File: bench/tb_encoder_biss_c_slave.sv
// Bench joining the master end and the encoder end over the link interface.
// Assumes a 50 MHz clock; frames run at the package link rate, so the run is long.
`timescale 1ns/1ns
module tb_encoder_biss_c_slave import ebc_pkg::*; ;
	// ==========================================================
	// Signals
	logic              clk, rst_n, enable, pos_ready, pos_valid, crc_error, vary, act_d;
	logic              cmd_valid, cmd_ready, cmd_write, rd_valid, zero_done, frame_active;
	logic [6:0]        cmd_addr;
	logic [7:0]        cmd_data, rd_data, temperature;
	logic [ERR_W-1:0]  err_conditions, warn_conditions;
	logic [POS_W-1:0]  raw_position, offset;
	logic [WORD_W-1:0] pos_data;
	logic [WORD_W-1:0] exp_q[$];
	int                fails, compares, frames, k, n, n0;

	ebc_link_if ebc_link_if_i ();
	ebc_master ebc_master_i (.clk(clk), .rst_n(rst_n), .link(ebc_link_if_i), .enable(enable),
		.pos_valid(pos_valid), .pos_ready(pos_ready), .pos_data(pos_data), .crc_error(crc_error),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .rd_valid(rd_valid), .rd_data(rd_data));
	ebc_slave ebc_slave_i (.clk(clk), .rst_n(rst_n), .link(ebc_link_if_i), .raw_position(raw_position),
		.err_conditions(err_conditions), .warn_conditions(warn_conditions), .temperature(temperature),
		.zero_done(zero_done), .frame_active(frame_active));
	ebc_link_asserts ebc_link_asserts_i (.clk(clk), .rst_n(rst_n), .ma(ebc_link_if_i.ma),
		.slo(ebc_link_if_i.slo));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================================
	// Tasks
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] want);
		compares++;
		if (seen !== want) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Holds the request until cmd_ready is seen at a sampling edge
	task automatic send_cmd(input logic wr, input logic [6:0] addr, input logic [7:0] data);
		int t;
		t = 0;
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_addr = addr;
		cmd_data = data;
		while (cmd_ready !== 1'b1 && t < 100000) begin
			@(negedge clk);
			t++;
		end
		@(negedge clk);
		cmd_valid = 1'b0;
	endtask

	function automatic logic [WORD_W-1:0] exp_word();
		return {raw_position - offset, ~|err_conditions, ~|warn_conditions};
	endfunction

	// ==========================================================
	// Frame monitor; sensor inputs change only between frames
	always @(posedge clk) begin
		if (rst_n === 1'b1) begin
			if (ebc_link_asserts_i.done_ff === 1'b1) begin
				check("frame word", 64'(ebc_link_asserts_i.cap_ff[57:6]), 64'(exp_word()));
				exp_q.push_back(exp_word());
				frames++;
			end
			if (crc_error !== 1'b0) check("crc_error", 64'(crc_error), 64'h0);
			if (zero_done === 1'b1) begin
				offset = raw_position;
				vary = 1'b1;
			end
			if (pos_valid === 1'b1 && pos_ready === 1'b1) begin
				check("fifo word", 64'(pos_data), 64'(exp_q.pop_front()));
			end
			if (act_d === 1'b1 && frame_active === 1'b0) begin
				k++;
				err_conditions <= k[0] ? 4'h1 << k[2:1] : 4'h0;
				warn_conditions <= k[1] ? 4'h8 >> k[3:2] : 4'h0;
				raw_position <= vary ? raw_position + 50'h2_4001_0C03 : raw_position;
			end
			act_d = frame_active;
		end
	end

	// Expected run near 118000 cycles: 43 frames of about 2700 cycles
	initial begin
		repeat (130000) @(posedge clk);
		$display("watchdog expired");
		fails++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst_n = 1'b0;
		enable = 1'b0;
		pos_ready = 1'b0;
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_addr = 7'h00;
		cmd_data = 8'h00;
		raw_position = 50'h2_89AB_CDEF_0123;
		err_conditions = 4'h0;
		warn_conditions = 4'h0;
		temperature = 8'h5C;
		offset = 50'h0;
		vary = 1'b0;
		act_d = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		enable = 1'b1;
		send_cmd(1'b1, ADDR_ZERO, ZERO_CODE);
		n = 0;
		while (zero_done !== 1'b1 && n < 70000) begin
			@(negedge clk);
			n++;
		end
		check("zero done", 64'(zero_done), 64'h1);
		$display("test zero position done");
		// Read runs on while the stream fills; master must stop when the buffer is full
		send_cmd(1'b0, ADDR_TEMP, 8'h00);
		n = 0;
		while (exp_q.size() < 32 && n < 90000) begin
			@(negedge clk);
			n++;
		end
		n0 = frames;
		repeat (1000) @(negedge clk);
		check("frames while full", 64'(frames), 64'(n0));
		check("words held", 64'(exp_q.size()), 64'h20);
		check("pos_valid full", 64'(pos_valid), 64'h1);
		n = 0;
		while (exp_q.size() > 0 && n < 2000) begin
			@(negedge clk);
			pos_ready = ~pos_ready;
			n++;
		end
		pos_ready = 1'b0;
		@(negedge clk);
		check("pos_valid empty", 64'(pos_valid), 64'h0);
		pos_ready = 1'b1;
		$display("test fill and drain done");
		n = 0;
		while (rd_valid !== 1'b1 && n < 60000) begin
			@(negedge clk);
			n++;
		end
		check("temperature", 64'(rd_data), 64'(temperature));
		$display("test temperature read done");
		tally_and_finish();
	end
endmodule // tb_encoder_biss_c_slave

// File: src/ebc_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module ebc_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wp_ff, nxt_wp, rp_ff, nxt_rp;
	logic         push, pop;

	assign in_ready  = (wp_ff - rp_ff) != (AW+1)'(DEPTH);
	assign out_valid = wp_ff != rp_ff;
	assign out_data  = mem[rp_ff[AW-1:0]];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
		nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			wp_ff <= nxt_wp;
			rp_ff <= nxt_rp;
		end
		if (push) begin
			mem[wp_ff[AW-1:0]] <= in_data;
		end
	end
endmodule // ebc_fifo

// File: src/ebc_link_if.sv
// Two-wire link between the master end and the encoder end.
// Both wires are one-way; the bench only connects the two modports.
`timescale 1ns/1ns
interface ebc_link_if;
	logic ma;
	logic slo;
	modport master (output ma, input slo);
	modport slave  (input ma, output slo);
endinterface

// File: src/ebc_master.sv
// Master end: makes the link clock, reads position frames, runs register commands.
// Assumes the encoder end on the far side of ebc_link_if.
`timescale 1ns/1ns
module ebc_master import ebc_pkg::*; (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Link
	ebc_link_if.master             link,
	// Frame control
	input  wire logic              enable,
	// Position stream
	output logic                   pos_valid,
	input  wire logic              pos_ready,
	output logic [WORD_W-1:0]      pos_data,
	output logic                   crc_error,
	// Register commands
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire logic              cmd_write,
	input  wire logic [6:0]        cmd_addr,
	input  wire logic [7:0]        cmd_data,
	output logic                   rd_valid,
	output logic [7:0]             rd_data
);
	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_RUN  = 3'b010,
		M_END  = 3'b100
	} ebc_mstate_e;

	ebc_mstate_e        st_ff, nxt_st;
	logic               ma_ff, nxt_ma, s1_ff, s2_ff;
	logic [4:0]         div_ff, nxt_div;
	logic [10:0]        gap_ff, nxt_gap;
	logic               got_ff, nxt_got;
	logic [6:0]         bit_ff, nxt_bit;
	logic [FRAME_W-1:0] rx_ff, nxt_rx;
	logic               crc_err_ff, nxt_crc_err;
	logic [CMD_W-1:0]   cdm_ff, nxt_cdm;
	logic [4:0]         ccnt_ff, nxt_ccnt;
	logic               pend_ff, nxt_pend;
	logic [3:0]         rcnt_ff, nxt_rcnt;
	logic [7:0]         rsr_ff, nxt_rsr, rd_ff, nxt_rd;
	logic               rdv_ff, nxt_rdv, crdy_ff, nxt_crdy;
	logic               fifo_rdy, push, end_go, crc_ok, cdm_bit;

	assign link.ma   = ma_ff;
	assign crc_error = crc_err_ff;
	assign cmd_ready = crdy_ff;
	assign rd_valid  = rdv_ff;
	assign rd_data   = rd_ff;
	assign cdm_bit   = (ccnt_ff != 5'h00) & cdm_ff[CMD_W-1];
	assign end_go    = (st_ff == M_END) & gap_ff[0] & s2_ff;
	// Inverted check value against the one computed here
	assign crc_ok    = rx_ff[CRC_W-1:0] == ~crc6_word(rx_ff[FRAME_W-2:CRC_W]);
	assign push      = end_go & crc_ok;

	// ==========================================================
	// Frame sequencer
	always_comb begin
		nxt_st = st_ff; nxt_ma = ma_ff; nxt_div = div_ff; nxt_gap = gap_ff;
		nxt_got = got_ff; nxt_bit = bit_ff; nxt_rx = rx_ff;
		nxt_crc_err = end_go & ~crc_ok;
		case (st_ff)
			M_IDLE: begin
				nxt_ma = 1'b1;
				if (gap_ff < GAP_CYC) nxt_gap = gap_ff + 11'h001;
				// No frame without room for its result
				else if (enable & fifo_rdy & s2_ff) begin
					nxt_st = M_RUN; nxt_ma = 1'b0; nxt_div = 5'h00;
					nxt_got = 1'b0; nxt_bit = 7'h00;
				end
			end
			M_RUN: begin
				nxt_div = div_ff + 5'h01;
				if (div_ff == MA_HALF - 5'h01) begin
					nxt_div = 5'h00;
					nxt_ma  = ~ma_ff;
					if (ma_ff) begin
						if (!got_ff) nxt_got = s2_ff;
						else begin
							// MSB first into the frame register
							nxt_rx  = {rx_ff[FRAME_W-2:0], s2_ff};
							nxt_bit = bit_ff + 7'h01;
						end
					end else if (bit_ff == FRAME_BITS) begin
						nxt_st = M_END; nxt_gap = 11'h000;
					end
				end
			end
			M_END: begin
				// Line level during the pause carries the command bit
				nxt_ma = ~cdm_bit;
				if (!s2_ff) nxt_gap = 11'h001;
				if (end_go) begin
					nxt_st = M_IDLE; nxt_ma = 1'b1; nxt_gap = 11'h000;
				end
			end
			default: begin
				nxt_st = M_IDLE; nxt_ma = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_ff <= M_IDLE; ma_ff <= 1'b1; div_ff <= 5'h00; gap_ff <= 11'h000;
			got_ff <= 1'b0; bit_ff <= 7'h00; rx_ff <= '0; crc_err_ff <= 1'b0;
			s1_ff <= 1'b1; s2_ff <= 1'b1;
		end else begin
			st_ff <= nxt_st; ma_ff <= nxt_ma; div_ff <= nxt_div; gap_ff <= nxt_gap;
			got_ff <= nxt_got; bit_ff <= nxt_bit; rx_ff <= nxt_rx; crc_err_ff <= nxt_crc_err;
			s1_ff <= link.slo; s2_ff <= s1_ff;
		end
	end

	// ==========================================================
	// Register channel: one command bit out and one reply bit in per frame
	always_comb begin
		nxt_cdm = cdm_ff; nxt_ccnt = ccnt_ff; nxt_pend = pend_ff;
		nxt_rcnt = rcnt_ff; nxt_rsr = rsr_ff; nxt_rd = rd_ff; nxt_rdv = 1'b0;
		if (cmd_valid & crdy_ff) begin
			// Start, direction, address, data
			nxt_cdm  = {1'b1, cmd_write, cmd_addr, cmd_data};
			nxt_ccnt = CMD_BITS;
			nxt_pend = ~cmd_write;
		end else if (end_go) begin
			if (ccnt_ff != 5'h00) begin
				nxt_cdm  = {cdm_ff[CMD_W-2:0], 1'b0};
				nxt_ccnt = ccnt_ff - 5'h01;
			end else if (pend_ff) begin
				if (rcnt_ff == 4'h0) begin
					if (rx_ff[FRAME_W-1]) nxt_rcnt = 4'h1;
				end else begin
					nxt_rsr  = {rsr_ff[6:0], rx_ff[FRAME_W-1]};
					nxt_rcnt = rcnt_ff + 4'h1;
					if (rcnt_ff == REPLY_BITS - 4'h1) begin
						nxt_rd = {rsr_ff[6:0], rx_ff[FRAME_W-1]};
						nxt_rdv = 1'b1; nxt_pend = 1'b0; nxt_rcnt = 4'h0;
					end
				end
			end
		end
		nxt_crdy = (nxt_st == M_IDLE) & (nxt_ccnt == 5'h00) & ~nxt_pend & ~(cmd_valid & crdy_ff);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cdm_ff <= '0; ccnt_ff <= 5'h00; pend_ff <= 1'b0; rcnt_ff <= 4'h0;
			rsr_ff <= 8'h00; rd_ff <= 8'h00; rdv_ff <= 1'b0; crdy_ff <= 1'b0;
		end else begin
			cdm_ff <= nxt_cdm; ccnt_ff <= nxt_ccnt; pend_ff <= nxt_pend; rcnt_ff <= nxt_rcnt;
			rsr_ff <= nxt_rsr; rd_ff <= nxt_rd; rdv_ff <= nxt_rdv; crdy_ff <= nxt_crdy;
		end
	end

	ebc_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_rdy),
		.in_data   (rx_ff[FRAME_W-2:CRC_W]),
		.out_valid (pos_valid),
		.out_ready (pos_ready),
		.out_data  (pos_data)
	);
endmodule // ebc_master

// File: src/ebc_pkg.sv
// Shared constants, frame layout and check-value helper for the serial encoder link.
// Assumes both ends run from one 50 MHz system clock.
package ebc_pkg;

	// ==========================================================
	// Clocking and link timing
	localparam int CLK_KHZ = 50000;
	// Link clock made by the master end; must stay within 500..10000 kHz
	// Half period of six cycles leaves room for both two-flop samplers in one bit time
	localparam int MA_KHZ  = 4166;
	localparam logic [4:0] MA_HALF = 5'(CLK_KHZ / (2 * MA_KHZ));
	localparam int BUSY_NS = 27300;
	localparam int TOUT_NS = 2000;
	localparam int GAP_NS  = 9000;
	// Least times round up to whole cycles
	localparam logic [10:0] BUSY_CYC = 11'((BUSY_NS * CLK_KHZ + 999999) / 1000000);
	localparam logic [10:0] TOUT_CYC = 11'((TOUT_NS * CLK_KHZ + 999999) / 1000000);
	localparam logic [10:0] GAP_CYC  = 11'((GAP_NS * CLK_KHZ + 999999) / 1000000);

	// ==========================================================
	// Frame layout
	localparam int MT_W    = 32;
	localparam int ST_W    = 18;
	localparam int POS_W   = MT_W + ST_W;
	localparam int WORD_W  = POS_W + 2;
	localparam int CRC_W   = 6;
	localparam int FRAME_W = WORD_W + CRC_W + 1;
	localparam logic [6:0] FRAME_BITS = 7'(FRAME_W);
	localparam logic [5:0] CRC_POLY   = 6'h03;
	localparam int ERR_W   = 4;

	// ==========================================================
	// Register channel
	localparam int CMD_W   = 17;
	localparam int REPLY_W = 9;
	localparam logic [4:0] CMD_BITS   = 5'(CMD_W);
	localparam logic [3:0] REPLY_BITS = 4'(REPLY_W);
	localparam logic [6:0] ADDR_TEMP  = 7'h75;
	localparam logic [6:0] ADDR_ZERO  = 7'h4A;
	localparam logic [7:0] ZERO_CODE  = 8'h03;
	localparam int FIFO_DEPTH = 32;

	// Polynomial x^6 + x + 1, MSB first, zero start value
	function automatic logic [CRC_W-1:0] crc6_word(input logic [WORD_W-1:0] d);
		logic [CRC_W-1:0] c;
		c = 6'h00;
		for (int i = WORD_W - 1; i >= 0; i--) begin
			c = {c[4:0], 1'b0} ^ ((c[5] ^ d[i]) ? CRC_POLY : 6'h00);
		end
		return c;
	endfunction

endpackage

// File: src/ebc_slave.sv
// Encoder end of the serial position link: answers frames clocked by the master,
// keeps the zero offset and serves the two register commands.
// Assumes the master end on ebc_link_if and same-clock sensor inputs.
`timescale 1ns/1ns

module ebc_slave import ebc_pkg::*; (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Link
	ebc_link_if.slave             link,
	// Sensor side
	input  wire logic [POS_W-1:0] raw_position,
	input  wire logic [ERR_W-1:0] err_conditions,
	input  wire logic [ERR_W-1:0] warn_conditions,
	input  wire logic [7:0]       temperature,
	// Status
	output logic                  zero_done,
	output logic                  frame_active
);
	typedef enum logic [3:0] {
		S_IDLE = 4'b0001,
		S_BUSY = 4'b0010,
		S_DATA = 4'b0100,
		S_TOUT = 4'b1000
	} ebc_sstate_e;

	// ==========================================================
	// Link clock sampling
	logic ma_s1_ff, ma_s2_ff, ma_d_ff;
	logic rise, fall;

	assign rise = ma_s2_ff & ~ma_d_ff;
	assign fall = ~ma_s2_ff & ma_d_ff;

	// ==========================================================
	// Frame state
	ebc_sstate_e        st_ff, nxt_st;
	logic               slo_ff, nxt_slo;
	logic [10:0]        cnt_ff, nxt_cnt;
	logic [1:0]         edg_ff, nxt_edg;
	logic [6:0]         bit_ff, nxt_bit;
	logic [FRAME_W-1:0] sh_ff, nxt_sh;
	logic               act_ff, nxt_act;

	// ==========================================================
	// Register channel state
	logic [POS_W-1:0]   off_ff, nxt_off;
	logic [CMD_W-2:0]   csr_ff, nxt_csr;
	logic [4:0]         ccnt_ff, nxt_ccnt;
	logic [REPLY_W-1:0] rsr_ff, nxt_rsr;
	logic [3:0]         rcnt_ff, nxt_rcnt;
	logic               zero_ff, nxt_zero;

	logic [WORD_W-1:0]  word;
	logic [CMD_W-2:0]   cmd;
	logic               start_evt, tout_evt, cdm, cds;

	assign link.slo     = slo_ff;
	assign zero_done    = zero_ff;
	assign frame_active = act_ff;

	// Position relative to the stored zero, then both status bits
	assign word = {raw_position - off_ff,
	               ~|err_conditions,
	               ~|warn_conditions};

	assign start_evt = (st_ff == S_IDLE) & fall;
	assign tout_evt  = (st_ff == S_TOUT) & (cnt_ff == TOUT_CYC);
	// A low line during the pause is a command bit of one
	assign cdm       = ~ma_s2_ff;
	assign cds       = (rcnt_ff != 4'h0) & rsr_ff[REPLY_W-1];
	assign cmd       = {csr_ff[CMD_W-3:0], cdm};

	always_comb begin
		nxt_st  = st_ff;
		nxt_slo = slo_ff;
		nxt_cnt = cnt_ff;
		nxt_edg = edg_ff;
		nxt_bit = bit_ff;
		nxt_sh  = sh_ff;
		case (st_ff)
			S_IDLE: begin
				nxt_slo = 1'b1;
				if (fall) begin
					nxt_st  = S_BUSY;
					nxt_slo = 1'b0;
					nxt_cnt = 11'h000;
					nxt_edg = 2'h0;
					// Snapshot taken at frame start keeps all fields coherent
					nxt_sh  = {cds, word, ~crc6_word(word)};
				end
			end
			S_BUSY: begin
				if (cnt_ff != BUSY_CYC) nxt_cnt = cnt_ff + 11'h001;
				if (rise) begin
					// Fixed part counted from the third rise, so two whole periods always precede it
					if (edg_ff == 2'h3 && cnt_ff == BUSY_CYC) begin
						nxt_st  = S_DATA;
						nxt_slo = 1'b1;
						nxt_bit = 7'h00;
						nxt_cnt = 11'h000;
					end else if (edg_ff != 2'h3) begin
						nxt_edg = edg_ff + 2'h1;
						nxt_cnt = 11'h000;
					end
				end
			end
			S_DATA: begin
				nxt_cnt = (rise | fall) ? 11'h000 : cnt_ff + 11'h001;
				if (rise) begin
					if (bit_ff == FRAME_BITS) begin
						nxt_st  = S_TOUT;
						nxt_slo = 1'b0;
					end else begin
						// One bit per rising edge, MSB first
						nxt_slo = sh_ff[FRAME_W-1];
						nxt_sh  = {sh_ff[FRAME_W-2:0], 1'b0};
						nxt_bit = bit_ff + 7'h01;
					end
				end else if (cnt_ff == TOUT_CYC) begin
					// Master gave up mid-frame: drop it without a command bit
					nxt_st  = S_IDLE;
					nxt_slo = 1'b1;
				end
			end
			S_TOUT: begin
				// Any edge restarts the pause, so it ends 2us after the last one
				nxt_cnt = (rise | fall) ? 11'h000 : cnt_ff + 11'h001;
				if (cnt_ff == TOUT_CYC) begin
					nxt_st  = S_IDLE;
					nxt_slo = 1'b1;
				end
			end
			default: begin
				nxt_st  = S_IDLE;
				nxt_slo = 1'b1;
			end
		endcase
		nxt_act = nxt_st != S_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ma_s1_ff <= 1'b1;
			ma_s2_ff <= 1'b1;
			ma_d_ff  <= 1'b1;
			st_ff    <= S_IDLE;
			slo_ff   <= 1'b1;
			cnt_ff   <= 11'h000;
			edg_ff   <= 2'h0;
			bit_ff   <= 7'h00;
			sh_ff    <= '0;
			act_ff   <= 1'b0;
		end else begin
			ma_s1_ff <= link.ma;
			ma_s2_ff <= ma_s1_ff;
			ma_d_ff  <= ma_s2_ff;
			st_ff    <= nxt_st;
			slo_ff   <= nxt_slo;
			cnt_ff   <= nxt_cnt;
			edg_ff   <= nxt_edg;
			bit_ff   <= nxt_bit;
			sh_ff    <= nxt_sh;
			act_ff   <= nxt_act;
		end
	end

	// ==========================================================
	// Register channel: start bit, direction, 7-bit address, 8-bit data
	always_comb begin
		nxt_off  = off_ff;
		nxt_csr  = csr_ff;
		nxt_ccnt = ccnt_ff;
		nxt_rsr  = rsr_ff;
		nxt_rcnt = rcnt_ff;
		nxt_zero = 1'b0;
		// Reply bit is consumed by the frame that carries it
		if (start_evt && rcnt_ff != 4'h0) begin
			nxt_rsr  = {rsr_ff[REPLY_W-2:0], 1'b0};
			nxt_rcnt = rcnt_ff - 4'h1;
		end
		if (tout_evt) begin
			if (ccnt_ff == 5'h00) begin
				if (cdm) nxt_ccnt = 5'h01;
			end else if (ccnt_ff == CMD_BITS - 5'h01) begin
				nxt_ccnt = 5'h00;
				if (cmd[15]) begin
					if (cmd[14:8] == ADDR_ZERO && cmd[7:0] == ZERO_CODE) begin
						// Whole 50-bit position reads zero at this point; later positions count from it
						nxt_off  = raw_position;
						nxt_zero = 1'b1;
					end
				end else begin
					// Every read is answered; unmapped addresses give zero
					nxt_rsr  = {1'b1, (cmd[14:8] == ADDR_TEMP) ? temperature : 8'h00};
					nxt_rcnt = REPLY_BITS;
				end
			end else begin
				nxt_csr  = cmd;
				nxt_ccnt = ccnt_ff + 5'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			off_ff  <= '0;
			csr_ff  <= '0;
			ccnt_ff <= 5'h00;
			rsr_ff  <= '0;
			rcnt_ff <= 4'h0;
			zero_ff <= 1'b0;
		end else begin
			off_ff  <= nxt_off;
			csr_ff  <= nxt_csr;
			ccnt_ff <= nxt_ccnt;
			rsr_ff  <= nxt_rsr;
			rcnt_ff <= nxt_rcnt;
			zero_ff <= nxt_zero;
		end
	end
endmodule // ebc_slave
